/* File: tcc_map.vh */
// Register indices, field positions, reset values and codes of the capture/compare block
`ifndef TCC_MAP_VH
`define TCC_MAP_VH

// ****************************************
// Register indices (byte address = 4 * index)
// ****************************************
`define TCC_IDX_CH0_LOW 8'hda
`define TCC_IDX_CH0_HIGH 8'hdb
`define TCC_IDX_CH1_LOW 8'hdc
`define TCC_IDX_CH1_HIGH 8'hdd
`define TCC_IDX_CH2_LOW 8'hde
`define TCC_IDX_CH2_HIGH 8'hdf
`define TCC_IDX_COUNT_MODE 8'he0
`define TCC_IDX_IRQ_STATUS 8'he1
`define TCC_IDX_IRQ_CLEAR 8'he2
`define TCC_IDX_IRQ_ENABLE 8'he3
`define TCC_IDX_CH_FLAGS 8'he4
`define TCC_IDX_COUNT_LOW 8'he8
`define TCC_IDX_COUNT_HIGH 8'he9
`define TCC_IDX_CH1_CONTROL 8'he6
`define TCC_IDX_CH2_CONTROL 8'he7

// ****************************************
// Channel control fields
// ****************************************
`define TCC_RADIO_BIT 7
`define TCC_IRQ_MASK_BIT 6
`define TCC_ACT_HI 5
`define TCC_ACT_LO 3
`define TCC_COMPARE_BIT 2
`define TCC_EDGE_HI 1
`define TCC_EDGE_LO 0

// ****************************************
// Reset values
// ****************************************
`define TCC_CONTROL_RESET 8'h40
`define TCC_VALUE_RESET 16'h0000
`define TCC_BYTE_RESET 8'h00
`define TCC_ZERO_COUNT 16'h0000

// ****************************************
// Output action codes
// ****************************************
`define TCC_ACT_SET 3'h0
`define TCC_ACT_CLEAR 3'h1
`define TCC_ACT_TOGGLE 3'h2
`define TCC_ACT_SET_UP 3'h3
`define TCC_ACT_CLEAR_UP 3'h4
`define TCC_ACT_CLR_CH0 3'h5
`define TCC_ACT_SET_CH0 3'h6
`define TCC_ACT_INIT 3'h7

// ****************************************
// Edge select and counter modes
// ****************************************
`define TCC_EDGE_NONE 2'h0
`define TCC_EDGE_RISE 2'h1
`define TCC_EDGE_FALL 2'h2
`define TCC_EDGE_BOTH 2'h3
`define TCC_MODE_HALT 2'h0
`define TCC_MODE_FREE 2'h1
`define TCC_MODE_MODULO 2'h2
`define TCC_MODE_UPDOWN 2'h3

`endif

/* File: tcc_channel.v */
// One capture/compare channel: control register, capture trigger and output action
`timescale 1ns/1ps
`include "tcc_map.vh"

module tcc_channel (
    // Clock and reset
    input wire clk_i,
    input wire rst_i,
    // Control register write
    input wire ctl_we_i,
    input wire [7:0] ctl_wdata_i,
    // Timer core view
    input wire [15:0] counter_i,
    input wire [15:0] ch0_value_i,
    input wire [15:0] own_value_i,
    input wire updown_i,
    input wire count_down_i,
    // Capture sources
    input wire pin_i,
    input wire radio_irq_i,
    // Results
    output reg [7:0] control_o,
    output reg out_o,
    output reg capture_o,
    output reg event_o
);

    wire [2:0] action = control_o[`TCC_ACT_HI:`TCC_ACT_LO];
    wire [1:0] edge_sel = control_o[`TCC_EDGE_HI:`TCC_EDGE_LO];
    wire compare_mode = control_o[`TCC_COMPARE_BIT];
    wire own_match = compare_mode && (counter_i == own_value_i);
    wire ch0_match = compare_mode && (counter_i == ch0_value_i);
    wire zero_hit = compare_mode && (counter_i == `TCC_ZERO_COUNT);
    wire source = control_o[`TCC_RADIO_BIT] ? radio_irq_i : pin_i; // RULE_04
    reg source_prev;
    reg next_out;
    reg capture_hit;

    // Capture trigger from edge select
    always @* begin
        case (edge_sel) // RULE_14
            `TCC_EDGE_RISE: capture_hit = source && !source_prev;
            `TCC_EDGE_FALL: capture_hit = !source && source_prev;
            `TCC_EDGE_BOTH: capture_hit = source != source_prev;
            default: capture_hit = 1'b0;
        endcase
    end

    // Output action; own match wins over a ch0 match or zero in the same cycle
    always @* begin
        next_out = out_o;
        case (action) // RULE_06
            `TCC_ACT_SET: if (own_match) next_out = 1'b1; // RULE_07
            `TCC_ACT_CLEAR: if (own_match) next_out = 1'b0; // RULE_07
            `TCC_ACT_TOGGLE: if (own_match) next_out = !out_o; // RULE_07
            `TCC_ACT_SET_UP: begin
                if (updown_i) begin
                    if (own_match) next_out = !count_down_i; // RULE_08
                end else if (own_match) begin
                    next_out = 1'b1;
                end else if (zero_hit) begin
                    next_out = 1'b0;
                end
            end
            `TCC_ACT_CLEAR_UP: begin
                if (updown_i) begin
                    if (own_match) next_out = count_down_i; // RULE_09
                end else if (own_match) begin
                    next_out = 1'b0;
                end else if (zero_hit) begin
                    next_out = 1'b1;
                end
            end
            `TCC_ACT_CLR_CH0: begin
                if (own_match) next_out = 1'b1; // RULE_10
                else if (ch0_match) next_out = 1'b0;
            end
            `TCC_ACT_SET_CH0: begin
                if (own_match) next_out = 1'b0; // RULE_11
                else if (ch0_match) next_out = 1'b1;
            end
            default: next_out = out_o;
        endcase
    end

    // Control register, output pin and event pulses
    always @(posedge clk_i) begin
        if (rst_i) begin
            control_o <= `TCC_CONTROL_RESET;
            out_o <= 1'b0;
            source_prev <= 1'b0;
            capture_o <= 1'b0;
            event_o <= 1'b0;
        end else begin
            source_prev <= source;
            capture_o <= !compare_mode && capture_hit; // RULE_18
            // Compare events raise the flag; capture events too
            event_o <= own_match || (!compare_mode && capture_hit);
            if (ctl_we_i && ctl_wdata_i[`TCC_ACT_HI:`TCC_ACT_LO] == `TCC_ACT_INIT) begin
                // Field keeps its old code; pin goes to the idle level of that code
                control_o <= {ctl_wdata_i[7:6], action, ctl_wdata_i[2:0]}; // RULE_12
                out_o <= (action == `TCC_ACT_CLEAR) || (action == `TCC_ACT_CLEAR_UP) ||
                         (action == `TCC_ACT_CLR_CH0);
            end else begin
                if (ctl_we_i) control_o <= ctl_wdata_i; // RULE_13
                out_o <= next_out;
            end
        end
    end

endmodule

/* File: tcc_top.v */
// Capture/compare channel block of a 16-bit timer with a classic Wishbone register slave
//
// Function
// (RULE_01) Low byte buffered until high byte commits
// (RULE_02) Channel 0 low byte uses same buffer
// (RULE_03) Compare-mode high write waits for counter zero
// (RULE_04) Control bit 7 selects radio capture source
// (RULE_05) Control bit 6 masks channel interrupt, resets 1
// (RULE_06) Bits 5:3 choose action on own match
// (RULE_07) Codes 000/001/010 set, clear, toggle
// (RULE_08) Code 011 set up, clear down/zero
// (RULE_09) Code 100 clear up, set down/zero
// (RULE_10) Code 101 clear on ch0, set own
// (RULE_11) Code 110 set on ch0, clear own
// (RULE_12) Code 111 initialises pin, field kept
// (RULE_13) Bit 2 selects capture or compare
// (RULE_14) Bits 1:0 select capture edges
// (RULE_15) Channel 2 mirrors channel 1 with own value
// (RULE_16) Counter modes: halt, free, modulo, up/down
// (RULE_17) Flags set by events, cleared writing zero
// (RULE_18) Capture copies counter and raises event
//
// The implementer's own choice: the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "tcc_map.vh"

module tcc_top (
    // Clock and reset
    input wire clk_i,
    input wire rst_i,
    // Wishbone slave
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [9:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    // Timer core side
    input wire ch0_compare_mode_i,
    input wire radio_irq_i,
    input wire [1:0] capture_pin_i,
    output reg [15:0] counter_value_o,
    output reg count_down_o,
    // Channel outputs and interrupt
    output wire [1:0] channel_out_o,
    output reg irq_o
);

    // ****************************************
    // Bus decode
    // ****************************************

    // Register index match, used by both write and read paths
    function hit;
        input [9:0] adr;
        input [7:0] idx;
        begin
            hit = (adr[9:2] == idx);
        end
    endfunction

    wire bus_req = wb_cyc_i && wb_stb_i;
    // Writes land on the edge where ack is seen high by the master
    wire wr = bus_req && wb_ack_o && wb_we_i && wb_sel_i[0];
    wire [7:0] wbyte = wb_dat_i[7:0];

    // ****************************************
    // State
    // ****************************************
    wire [15:0] ch_value [0:2];
    reg [1:0] count_mode;
    reg [2:0] irq_status;
    reg [2:0] irq_enable;
    reg [2:0] ch_flags;
    reg [31:0] next_rdata;

    wire [7:0] ctl [1:2];
    wire [1:0] ch_capture;
    wire [1:0] ch_event;
    wire [2:0] compare_mode = {ctl[2][`TCC_COMPARE_BIT], ctl[1][`TCC_COMPARE_BIT], ch0_compare_mode_i};
    wire updown = (count_mode == `TCC_MODE_UPDOWN);
    wire at_zero = (counter_value_o == `TCC_ZERO_COUNT);
    wire ch0_event = ch0_compare_mode_i && (counter_value_o == ch_value[0]);
    wire [2:0] irq_mask = {ctl[2][`TCC_IRQ_MASK_BIT], ctl[1][`TCC_IRQ_MASK_BIT], 1'b1};
    wire [2:0] raw_event = {ch_event, ch0_event};
    wire [2:0] irq_set = raw_event & irq_mask; // RULE_05
    wire irq_clear_wr = wr && hit(wb_adr_i, `TCC_IDX_IRQ_CLEAR);
    wire flags_wr = wr && hit(wb_adr_i, `TCC_IDX_CH_FLAGS);

    // ****************************************
    // Channels 1 and 2
    // ****************************************
    genvar g;
    generate
        for (g = 1; g <= 2; g = g + 1) begin : gen_ch
            wire ctl_we = wr && hit(wb_adr_i, (g == 1) ? `TCC_IDX_CH1_CONTROL : `TCC_IDX_CH2_CONTROL);
            tcc_channel u_ch (
                .clk_i(clk_i),
                .rst_i(rst_i),
                .ctl_we_i(ctl_we),
                .ctl_wdata_i(wbyte),
                .counter_i(counter_value_o),
                .ch0_value_i(ch_value[0]),
                .own_value_i(ch_value[g]), // RULE_15
                .updown_i(updown),
                .count_down_i(count_down_o),
                .pin_i(capture_pin_i[g-1]),
                .radio_irq_i(radio_irq_i),
                .control_o(ctl[g]),
                .out_o(channel_out_o[g-1]),
                .capture_o(ch_capture[g-1]),
                .event_o(ch_event[g-1])
            );
        end
    endgenerate

    // ****************************************
    // Value registers for channels 0..2
    // ****************************************
    genvar v;
    generate
        for (v = 0; v <= 2; v = v + 1) begin : gen_val
            wire [7:0] idx_low = (v == 0) ? `TCC_IDX_CH0_LOW : ((v == 1) ? `TCC_IDX_CH1_LOW : `TCC_IDX_CH2_LOW);
            wire [7:0] idx_high = (v == 0) ? `TCC_IDX_CH0_HIGH : ((v == 1) ? `TCC_IDX_CH1_HIGH : `TCC_IDX_CH2_HIGH);
            wire low_wr = wr && hit(wb_adr_i, idx_low);
            wire high_wr = wr && hit(wb_adr_i, idx_high);
            wire cap = (v != 0) && ch_capture[(v == 0) ? 0 : v - 1];
            reg [15:0] value;
            reg [7:0] low_buf;
            reg [15:0] pend_value;
            reg pend;
            assign ch_value[v] = value;

            // Shadow byte, deferred compare value and active value; one process per channel
            always @(posedge clk_i) begin
                if (rst_i) begin
                    value <= `TCC_VALUE_RESET;
                    low_buf <= `TCC_BYTE_RESET; // RULE_02
                    pend_value <= `TCC_VALUE_RESET;
                    pend <= 1'b0;
                end else begin
                    if (low_wr) low_buf <= wbyte; // RULE_01
                    if (high_wr && compare_mode[v]) begin
                        // Compare value changes only at counter zero
                        pend_value <= {wbyte, low_buf}; // RULE_03
                        pend <= 1'b1;
                    end else if (high_wr) begin
                        value <= {wbyte, low_buf}; // RULE_01
                        pend <= 1'b0;
                    end else if (pend && at_zero) begin
                        value <= pend_value; // RULE_03
                        pend <= 1'b0;
                    end else if (cap) begin
                        // Counter sampled one cycle after the edge was seen
                        value <= counter_value_o; // RULE_18
                    end
                end
            end
        end
    endgenerate

    // ****************************************
    // Counter
    // ****************************************

    // Counts every clock outside halt mode; the prescaler lives in the timer core, not here
    always @(posedge clk_i) begin
        if (rst_i) begin
            counter_value_o <= `TCC_ZERO_COUNT;
            count_down_o <= 1'b0;
            count_mode <= `TCC_MODE_HALT;
        end else begin
            if (wr && hit(wb_adr_i, `TCC_IDX_COUNT_MODE)) count_mode <= wbyte[1:0];
            case (count_mode) // RULE_16
                `TCC_MODE_FREE: begin
                    counter_value_o <= counter_value_o + 16'h0001;
                    count_down_o <= 1'b0;
                end
                `TCC_MODE_MODULO: begin
                    count_down_o <= 1'b0;
                    if (counter_value_o >= ch_value[0]) counter_value_o <= `TCC_ZERO_COUNT;
                    else counter_value_o <= counter_value_o + 16'h0001;
                end
                `TCC_MODE_UPDOWN: begin
                    if (!count_down_o && counter_value_o >= ch_value[0]) begin
                        count_down_o <= (ch_value[0] != `TCC_ZERO_COUNT);
                        if (ch_value[0] != `TCC_ZERO_COUNT) counter_value_o <= counter_value_o - 16'h0001;
                    end else if (count_down_o && at_zero) begin
                        count_down_o <= 1'b0;
                        counter_value_o <= counter_value_o + 16'h0001;
                    end else if (count_down_o) begin
                        counter_value_o <= counter_value_o - 16'h0001;
                    end else begin
                        counter_value_o <= counter_value_o + 16'h0001;
                    end
                end
                default: count_down_o <= count_down_o;
            endcase
        end
    end

    // ****************************************
    // Interrupt flags and line
    // ****************************************

    // Set wins over a clear arriving in the same cycle
    always @(posedge clk_i) begin
        if (rst_i) begin
            irq_status <= 3'h0;
            irq_enable <= 3'h0;
            ch_flags <= 3'h0;
            irq_o <= 1'b0;
        end else begin
            if (wr && hit(wb_adr_i, `TCC_IDX_IRQ_ENABLE)) irq_enable <= wbyte[2:0];
            irq_status <= (irq_status & ~(irq_clear_wr ? wbyte[2:0] : 3'h0)) | irq_set;
            // Writing 1 leaves a flag alone, writing 0 clears it
            ch_flags <= (ch_flags & (flags_wr ? wbyte[2:0] : 3'h7)) | raw_event; // RULE_17
            irq_o <= |(irq_status & irq_enable);
        end
    end

    // ****************************************
    // Read path and acknowledge
    // ****************************************

    // Unmapped and write-only addresses read as zero
    always @* begin
        next_rdata = 32'h0000_0000;
        if (hit(wb_adr_i, `TCC_IDX_CH0_LOW)) next_rdata[7:0] = ch_value[0][7:0];
        if (hit(wb_adr_i, `TCC_IDX_CH0_HIGH)) next_rdata[7:0] = ch_value[0][15:8];
        if (hit(wb_adr_i, `TCC_IDX_CH1_LOW)) next_rdata[7:0] = ch_value[1][7:0];
        if (hit(wb_adr_i, `TCC_IDX_CH1_HIGH)) next_rdata[7:0] = ch_value[1][15:8];
        if (hit(wb_adr_i, `TCC_IDX_CH2_LOW)) next_rdata[7:0] = ch_value[2][7:0];
        if (hit(wb_adr_i, `TCC_IDX_CH2_HIGH)) next_rdata[7:0] = ch_value[2][15:8];
        if (hit(wb_adr_i, `TCC_IDX_CH1_CONTROL)) next_rdata[7:0] = ctl[1];
        if (hit(wb_adr_i, `TCC_IDX_CH2_CONTROL)) next_rdata[7:0] = ctl[2];
        if (hit(wb_adr_i, `TCC_IDX_COUNT_MODE)) next_rdata[1:0] = count_mode;
        if (hit(wb_adr_i, `TCC_IDX_IRQ_STATUS)) next_rdata[2:0] = irq_status;
        if (hit(wb_adr_i, `TCC_IDX_IRQ_ENABLE)) next_rdata[2:0] = irq_enable;
        if (hit(wb_adr_i, `TCC_IDX_CH_FLAGS)) next_rdata[2:0] = ch_flags;
        if (hit(wb_adr_i, `TCC_IDX_COUNT_LOW)) next_rdata[7:0] = counter_value_o[7:0];
        if (hit(wb_adr_i, `TCC_IDX_COUNT_HIGH)) next_rdata[7:0] = counter_value_o[15:8];
    end

    // One-cycle answer; ack drops the cycle after it is given
    always @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= bus_req && !wb_ack_o;
            wb_dat_o <= (bus_req && !wb_ack_o && !wb_we_i) ? next_rdata : 32'h0000_0000;
        end
    end

endmodule

/* File: tcc_top_props.sv */
// Port-level assertions for the capture/compare block
`timescale 1ns/1ps

module tcc_top_props (
    // Clock and reset
    input wire clk_i,
    input wire rst_i,
    // Register bus
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [31:0] wb_dat_o,
    input wire wb_ack_o,
    // Timer and channel outputs
    input wire [15:0] counter_value_o,
    input wire count_down_o,
    input wire [1:0] channel_out_o,
    input wire irq_o
);
    // ****************************************
    // Bus handshake
    // ****************************************
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    property p_ack_answer;
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
    endproperty
    a_ack_answer: assert property (p_ack_answer) else $error("no ack after request");

    property p_ack_pulse;
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");

    property p_ack_cause;
        wb_ack_o |-> $past(wb_cyc_i && wb_stb_i);
    endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("ack without request");

    property p_dat_idle;
        !wb_ack_o |-> wb_dat_o == 32'h00000000;
    endproperty
    a_dat_idle: assert property (p_dat_idle) else $error("read data outside ack");

    // ****************************************
    // Reset and counter movement
    // ****************************************
    property p_reset_out;
        $fell(rst_i) |-> channel_out_o == 2'h0 && !irq_o && counter_value_o == 16'h0000 && !count_down_o;
    endproperty
    a_reset_out: assert property (p_reset_out) else $error("outputs not cleared by reset");

    // Counter moves by one step or wraps to zero, never jumps
    property p_cnt_step;
        $changed(counter_value_o) |-> counter_value_o == $past(counter_value_o) + 16'h0001
            || counter_value_o == $past(counter_value_o) - 16'h0001 || counter_value_o == 16'h0000;
    endproperty
    a_cnt_step: assert property (p_cnt_step) else $error("counter jumped");

    property p_cnt_up;
        !count_down_o && !$past(count_down_o) && $changed(counter_value_o) && counter_value_o != 16'h0000
            |-> counter_value_o == $past(counter_value_o) + 16'h0001;
    endproperty
    a_cnt_up: assert property (p_cnt_up) else $error("counter not rising while up");

    // Direction flag turns in the same cycle as the counter at the turns, yet both samples must agree
    property p_cnt_down;
        count_down_o && $past(count_down_o) && $changed(counter_value_o) && $past(counter_value_o) != 16'h0000
            |-> counter_value_o == $past(counter_value_o) - 16'h0001;
    endproperty
    a_cnt_down: assert property (p_cnt_down) else $error("counter not falling while down");

    // Main scenarios reached
    c_read: cover property (wb_ack_o && !wb_we_i);
    c_out_rise: cover property ($rose(channel_out_o[0]));
    c_irq: cover property ($rose(irq_o));
    c_down: cover property ($rose(count_down_o));
endmodule

bind tcc_top tcc_top_props u_tcc_top_props (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .counter_value_o(counter_value_o),
    .count_down_o(count_down_o), .channel_out_o(channel_out_o), .irq_o(irq_o));

/* File: test_tcc_top.sv */
// Self-checking testbench of the capture/compare block
`timescale 1ns/1ps
`include "tcc_map.vh"

module test_tcc_top;
    // ****************************************
    // Stimulus, observation and bookkeeping
    // ****************************************
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [9:0] wb_adr_i = 10'h000;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h00000000;
    logic ch0_compare_mode_i = 1'b0;
    logic radio_irq_i = 1'b0;
    logic [1:0] capture_pin_i = 2'h0;
    wire [31:0] wb_dat_o;
    wire wb_ack_o;
    wire [15:0] counter_value_o;
    wire count_down_o;
    wire [1:0] channel_out_o;
    wire irq_o;
    int fail_count = 0;
    int samples_checked = 0;
    int cycles = 0;
    int i;
    logic [15:0] cap_val, v16;
    // Action, first wait point and level, second wait point and level
    logic [2:0] act_tab [7] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h6, 3'h5};
    logic [7:0] p1_tab [7] = '{8'h20, 8'h20, 8'h20, 8'h20, 8'h20, 8'hff, 8'hff};
    logic e1_tab [7] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0};
    logic [7:0] p2_tab [7] = '{8'h20, 8'h20, 8'h20, 8'h00, 8'h00, 8'h20, 8'h20};
    logic e2_tab [7] = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1};

    tcc_top u_tcc_top (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .ch0_compare_mode_i(ch0_compare_mode_i), .radio_irq_i(radio_irq_i),
        .capture_pin_i(capture_pin_i), .counter_value_o(counter_value_o), .count_down_o(count_down_o),
        .channel_out_o(channel_out_o), .irq_o(irq_o));

    // 250 MHz clock
    always #2 clk_i = ~clk_i;

    // ****************************************
    // Tasks
    // ****************************************
    task automatic end_of_test();
        $display("Checks made: %0d, mismatches: %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Classic single cycle; held until ack is sampled, released at that edge
    task automatic wb_xfer(input logic we, input logic [7:0] idx, input logic [7:0] wd, output logic [7:0] rd);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_sel_i <= 4'h1;
        wb_adr_i <= {idx, 2'b00};
        wb_dat_i <= {24'h000000, wd};
        @(posedge clk_i);
        while (wb_ack_o !== 1'b1) @(posedge clk_i);
        rd = wb_dat_o[7:0];
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
        logic [7:0] unused;
        wb_xfer(1'b1, idx, wd, unused);
    endtask

    task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
        logic [7:0] got;
        wb_xfer(1'b0, idx, 8'h00, got);
        chk({8'h00, got}, {8'h00, exp});
    endtask

    // Low byte first so the high write commits both halves
    task automatic wr16(input logic [7:0] idx, input logic [15:0] v);
        wr(idx, v[7:0]);
        wr(idx + 8'h01, v[15:8]);
    endtask

    task automatic rd16(input logic [7:0] idx, output logic [15:0] v);
        logic [7:0] lo;
        logic [7:0] hi;
        wb_xfer(1'b0, idx, 8'h00, lo);
        wb_xfer(1'b0, idx + 8'h01, 8'h00, hi);
        v = {hi, lo};
    endtask

    // Waits for a counter value, then lets the output action land
    task automatic wait_cnt(input logic [7:0] v);
        int n;
        n = 0;
        @(posedge clk_i);
        while (counter_value_o !== {8'h00, v} && n < 2000) begin
            @(posedge clk_i);
            n++;
        end
        chk({15'h0000, n < 2000}, 16'h0001);
        repeat (2) @(posedge clk_i);
        #1;
    endtask

    // Watchdog; a full run needs far fewer cycles
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            end_of_test();
        end
    end

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        rd_chk(`TCC_IDX_CH1_CONTROL, `TCC_CONTROL_RESET);
        rd_chk(`TCC_IDX_CH2_CONTROL, `TCC_CONTROL_RESET);
        rd_chk(`TCC_IDX_CH0_LOW, `TCC_BYTE_RESET);
        wr(`TCC_IDX_CH1_LOW, 8'h34);
        rd_chk(`TCC_IDX_CH1_LOW, 8'h00);
        wr(`TCC_IDX_CH1_HIGH, 8'h12);
        rd_chk(`TCC_IDX_CH1_LOW, 8'h34);
        rd_chk(`TCC_IDX_CH1_HIGH, 8'h12);
        wr(`TCC_IDX_CH0_LOW, 8'hff);
        rd_chk(`TCC_IDX_CH0_LOW, 8'h00);
        wr(`TCC_IDX_CH0_HIGH, 8'h00);
        rd_chk(`TCC_IDX_CH0_LOW, 8'hff);
        // Unmapped index reads zero and keeps nothing
        wr(8'hf0, 8'h55);
        rd_chk(8'hf0, 8'h00);
        wr16(`TCC_IDX_CH1_LOW, 16'h0020);
        wr16(`TCC_IDX_CH2_LOW, 16'h0030);
        wr(`TCC_IDX_COUNT_MODE, {6'h00, `TCC_MODE_MODULO});
        for (i = 0; i < 7; i++) begin
            wr(`TCC_IDX_CH1_CONTROL, {2'b01, act_tab[i], 3'b100});
            wait_cnt(p1_tab[i]);
            chk({15'h0000, channel_out_o[0]}, {15'h0000, e1_tab[i]});
            wait_cnt(p2_tab[i]);
            chk({15'h0000, channel_out_o[0]}, {15'h0000, e2_tab[i]});
        end
        // Initialise code: field kept, pin forced high for a clearing action
        wr(`TCC_IDX_CH1_CONTROL, 8'h4c);
        wait_cnt(8'h20);
        wr(`TCC_IDX_CH1_CONTROL, 8'h7c);
        rd_chk(`TCC_IDX_CH1_CONTROL, 8'h4c);
        chk({15'h0000, channel_out_o[0]}, 16'h0001);
        // Compare-mode value update waits for counter zero
        wait_cnt(8'h10);
        wr16(`TCC_IDX_CH1_LOW, 16'h0040);
        rd_chk(`TCC_IDX_CH1_LOW, 8'h20);
        wait_cnt(8'h00);
        rd_chk(`TCC_IDX_CH1_LOW, 8'h40);
        wr(`TCC_IDX_CH2_CONTROL, 8'h44);
        wait_cnt(8'h30);
        chk({15'h0000, channel_out_o[1]}, 16'h0001);
        wr(`TCC_IDX_CH2_CONTROL, 8'h4c);
        wait_cnt(8'h30);
        chk({15'h0000, channel_out_o[1]}, 16'h0000);
        // Up/down counting with the set-up, clear-down action
        wr(`TCC_IDX_CH1_CONTROL, 8'h5c);
        wr(`TCC_IDX_COUNT_MODE, {6'h00, `TCC_MODE_UPDOWN});
        wait_cnt(8'hff);
        chk({15'h0000, count_down_o}, 16'h0001);
        wait_cnt(8'h40);
        chk({15'h0000, channel_out_o[0]}, 16'h0000);
        wait_cnt(8'h40);
        chk({15'h0000, channel_out_o[0]}, 16'h0001);
        chk({15'h0000, count_down_o}, 16'h0000);
        wr(`TCC_IDX_COUNT_MODE, {6'h00, `TCC_MODE_HALT});
        rd16(`TCC_IDX_COUNT_LOW, cap_val);
        rd16(`TCC_IDX_COUNT_LOW, v16);
        chk(v16, cap_val);
        // Falling-edge capture with interrupt enabled
        wr(`TCC_IDX_IRQ_CLEAR, 8'h07);
        wr(`TCC_IDX_CH_FLAGS, 8'h00);
        wr(`TCC_IDX_CH1_CONTROL, 8'h42);
        wr16(`TCC_IDX_CH1_LOW, 16'h1234);
        wr(`TCC_IDX_IRQ_ENABLE, 8'h02);
        capture_pin_i <= 2'h1;
        rd16(`TCC_IDX_CH1_LOW, v16);
        chk(v16, 16'h1234);
        chk({15'h0000, irq_o}, 16'h0000);
        capture_pin_i <= 2'h0;
        repeat (3) @(posedge clk_i); // Capture lands two edges after the pin
        rd16(`TCC_IDX_CH1_LOW, v16);
        chk(v16, cap_val);
        chk({15'h0000, irq_o}, 16'h0001);
        rd_chk(`TCC_IDX_CH_FLAGS, 8'h02);
        wr(`TCC_IDX_CH_FLAGS, 8'hff);
        rd_chk(`TCC_IDX_CH_FLAGS, 8'h02);
        wr(`TCC_IDX_CH_FLAGS, 8'h00);
        rd_chk(`TCC_IDX_CH_FLAGS, 8'h00);
        rd_chk(`TCC_IDX_IRQ_STATUS, 8'h02);
        wr(`TCC_IDX_IRQ_CLEAR, 8'h02);
        rd_chk(`TCC_IDX_IRQ_STATUS, 8'h00);
        chk({15'h0000, irq_o}, 16'h0000);
        // Radio source, rising edge, mask clear
        wr(`TCC_IDX_CH1_CONTROL, 8'h81);
        wr16(`TCC_IDX_CH1_LOW, 16'h1234);
        capture_pin_i <= 2'h1;
        rd16(`TCC_IDX_CH1_LOW, v16);
        chk(v16, 16'h1234);
        radio_irq_i <= 1'b1;
        repeat (3) @(posedge clk_i); // Capture lands two edges after radio_irq_i rises
        rd16(`TCC_IDX_CH1_LOW, v16);
        chk(v16, cap_val);
        rd_chk(`TCC_IDX_IRQ_STATUS, 8'h00);
        rd_chk(`TCC_IDX_CH_FLAGS, 8'h02);
        chk({15'h0000, irq_o}, 16'h0000);
        end_of_test();
    end
endmodule
